// ===== idtp_regs.vh
`ifndef IDTP_REGS_VH
`define IDTP_REGS_VH

// ************************************************************
// port offsets within the four-port window
// ************************************************************
`define IDTP_OFS_ISO_LO     2'h0
`define IDTP_OFS_ISO_HI     2'h1
`define IDTP_OFS_TTL_LO     2'h2
`define IDTP_OFS_TTL_HI     2'h3

// ************************************************************
// decode field and switch defaults
// ************************************************************
`define IDTP_ADDR_W         10
`define IDTP_DEC_HI         9
`define IDTP_DEC_LO         2
`define IDTP_SW_DEFAULT     8'h3f
`define IDTP_OUT_RESET      16'h0000

// ************************************************************
// interrupt jumper encodings
// ************************************************************
`define IDTP_SRC_ISO0       2'h0
`define IDTP_SRC_ISO1       2'h1
`define IDTP_SRC_TTL0       2'h2
`define IDTP_SRC_TTL1       2'h3
`define IDTP_EDGE_RISE      1'b0
`define IDTP_IRQ_NONE       3'h0
`define IDTP_IRQ_MIN        3'h2
`define IDTP_IRQ_MAX        3'h7
`define IDTP_IRQ_LINES      6
`define IDTP_IRQ_PULSE      8'h04
`define IDTP_PRIME_LEN      4

`endif

// ===== idtp_sync.v
`timescale 1ns/10ps

// ************************************************************
// two-stage synchroniser for a vector of pins
// ************************************************************
module idtp_sync #(
	parameter W = 16
) (
	input  wire         clk,
	input  wire         rst_b,
	input  wire [W-1:0] d,
	output wire [W-1:0] q
);

	reg [W-1:0] meta_ff;
	reg [W-1:0] sync_ff;

	// first stage is read only by the second stage
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= {W{1'b0}};
			sync_ff <= {W{1'b0}};
		end else begin
			meta_ff <= d;
			sync_ff <= meta_ff;
		end
	end

	assign q = sync_ff;

endmodule

// ===== idtp_dio_port.v
`timescale 1ns/10ps
`include "idtp_regs.vh"

// Overview of operation
// (RL1) Card answers exactly four consecutive I/O addresses from its base, no others.
// (RL2) Base address selectable from hex 200 to 3F0 on four-byte steps; the decode also accepts bases 3F4 to 3FC.
// (RL3) Address bits 9..2 compared with eight switches; switch on means bit zero.
// (RL4) Default switch setting places the ports at hex 300 through 303.
// (RL5) Offsets 0,1 isolated channels; offsets 2,3 TTL channels.
// (RL6) Each input and output channel maps to one bit of a port.
// (RL7) Interrupt source: isolated input 0 or 1, or TTL input 0 or 1.
// (RL8) Interrupt on rising or falling edge of source; rising is default.
// (RL9) Interrupt routed to request line 2 to 7, or none which disables it.
// (RL10) Reads return input levels; writes latch and drive the outputs.
// (RL11) One interrupt request per qualifying edge while a line is selected; an edge during a pulse is dropped.
module idtp_dio_port #(
	parameter                 CH_W      = 16,
	parameter [7:0]           IRQ_PULSE = `IDTP_IRQ_PULSE
) (
	input  wire                       clk,
	input  wire                       rst_b,
	input  wire [`IDTP_ADDR_W-1:0]    bus_addr,
	input  wire                       bus_aen,
	input  wire                       bus_ior_b,
	input  wire                       bus_iow_b,
	input  wire [7:0]                 bus_din,
	output wire [7:0]                 bus_dout,
	output wire                       bus_dout_oe_b,
	input  wire [7:0]                 base_select_switch,
	input  wire [2:0]                 irq_line_jumper,
	input  wire                       trigger_edge_jumper,
	input  wire [1:0]                 irq_source_jumper,
	input  wire [CH_W-1:0]            isolated_input,
	input  wire [CH_W-1:0]            ttl_input,
	output wire [CH_W-1:0]            isolated_output,
	output wire [CH_W-1:0]            ttl_output,
	output wire [`IDTP_IRQ_LINES-1:0] irq_req
);

	// ************************************************************
	// functions
	// ************************************************************

	// pick one byte of a channel group by the low offset bit
	function [7:0] pick_byte;
		input [CH_W-1:0] grp;
		input            hi;
		begin
			pick_byte = hi ? grp[15:8] : grp[7:0];
		end
	endfunction

	// ************************************************************
	// pin synchronisers
	// ************************************************************
	wire [CH_W-1:0] iso_in_s;
	wire [CH_W-1:0] ttl_in_s;
	wire [2:0]      bus_ctl_s;

	idtp_sync #(.W(CH_W)) u_sync_iso (
		.clk   (clk),
		.rst_b (rst_b),
		.d     (isolated_input),
		.q     (iso_in_s)
	);

	idtp_sync #(.W(CH_W)) u_sync_ttl (
		.clk   (clk),
		.rst_b (rst_b),
		.d     (ttl_input),
		.q     (ttl_in_s)
	);

	// bus strobes are async to clk; address and data are held stable across them
	idtp_sync #(.W(3)) u_sync_bus (
		.clk   (clk),
		.rst_b (rst_b),
		.d     ({bus_aen, ~bus_ior_b, ~bus_iow_b}),
		.q     (bus_ctl_s)
	);

	wire aen_s = bus_ctl_s[2];
	wire rd_s  = bus_ctl_s[1];
	wire wr_s  = bus_ctl_s[0];

	// address and write data ride through the same two stages as the strobes,
	// so they line up with the synchronised strobe edge when they settle at the pins no later than the strobe
	wire [`IDTP_ADDR_W+7:0] adr_din_s;
	wire [`IDTP_ADDR_W-1:0] addr_s;
	wire [7:0]              din_s;

	idtp_sync #(.W(`IDTP_ADDR_W + 8)) u_sync_adr (
		.clk   (clk),
		.rst_b (rst_b),
		.d     ({bus_addr, bus_din}),
		.q     (adr_din_s)
	);

	assign addr_s = adr_din_s[`IDTP_ADDR_W+7:8];
	assign din_s  = adr_din_s[7:0];

	// ************************************************************
	// switch and jumper synchronisers
	// ************************************************************
	reg  [7:0] sw_meta_ff;
	reg  [7:0] sw_ff;
	reg  [5:0] jp_meta_ff;
	reg  [5:0] jp_ff;
	wire [2:0] line_s   = jp_ff[5:3];
	wire       edge_s   = jp_ff[2];
	wire [1:0] srcsel_s = jp_ff[1:0];

	// settings are static in use, but one moved with power on must not go metastable;
	// reset loads the shipped defaults so decode is sane right after release
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sw_meta_ff <= `IDTP_SW_DEFAULT;                                          // RL4
			sw_ff      <= `IDTP_SW_DEFAULT;                                          // RL4
			jp_meta_ff <= {`IDTP_IRQ_NONE, `IDTP_EDGE_RISE, `IDTP_SRC_ISO0};
			jp_ff      <= {`IDTP_IRQ_NONE, `IDTP_EDGE_RISE, `IDTP_SRC_ISO0};        // RL8
		end else begin
			sw_meta_ff <= base_select_switch;
			sw_ff      <= sw_meta_ff;
			jp_meta_ff <= {irq_line_jumper, trigger_edge_jumper, irq_source_jumper};
			jp_ff      <= jp_meta_ff;
		end
	end

	// ************************************************************
	// address decode
	// ************************************************************
	// switch on reads as 1 and means address bit 0, so the expected bits are inverted
	wire [7:0] base_bits = ~sw_ff;                                                       // RL3
	// bit 9 must be set, which confines the window to 200..3ff in four-byte steps
	wire       hit = !aen_s && base_bits[7]
	                 && (addr_s[`IDTP_DEC_HI:`IDTP_DEC_LO] == base_bits);                 // RL1 RL2
	wire [1:0] ofs = addr_s[`IDTP_DEC_LO-1:0];                                           // RL1

	// ************************************************************
	// write strobe edge and output latches
	// ************************************************************
	reg             wr_d_ff;
	reg [CH_W-1:0]  iso_out_ff;
	reg [CH_W-1:0]  ttl_out_ff;
	reg [CH_W-1:0]  nxt_iso_out;
	reg [CH_W-1:0]  nxt_ttl_out;
	wire            wr_go = wr_s && !wr_d_ff && hit;

	// one write per strobe, taken on its synchronised leading edge
	always @* begin
		nxt_iso_out = iso_out_ff;
		nxt_ttl_out = ttl_out_ff;
		if (wr_go) begin
			case (ofs)
				`IDTP_OFS_ISO_LO: nxt_iso_out[7:0]  = din_s;                         // RL5 RL6
				`IDTP_OFS_ISO_HI: nxt_iso_out[15:8] = din_s;                         // RL5 RL6
				`IDTP_OFS_TTL_LO: nxt_ttl_out[7:0]  = din_s;                         // RL5 RL6
				`IDTP_OFS_TTL_HI: nxt_ttl_out[15:8] = din_s;                         // RL5 RL6
				default: begin
					nxt_iso_out = iso_out_ff;
				end
			endcase
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_d_ff    <= 1'b0;
			iso_out_ff <= `IDTP_OUT_RESET;
			ttl_out_ff <= `IDTP_OUT_RESET;
		end else begin
			wr_d_ff    <= wr_s;
			iso_out_ff <= nxt_iso_out;                                               // RL10
			ttl_out_ff <= nxt_ttl_out;                                               // RL10
		end
	end

	assign isolated_output = iso_out_ff;                                                 // RL6
	assign ttl_output      = ttl_out_ff;                                                 // RL6

	// ************************************************************
	// read data path
	// ************************************************************
	reg  [7:0] rd_data_ff;
	reg        rd_oe_ff;
	reg  [7:0] nxt_rd_data;

	// input levels are sampled every cycle while the read stands
	always @* begin
		case (ofs)
			`IDTP_OFS_ISO_LO,
			`IDTP_OFS_ISO_HI: nxt_rd_data = pick_byte(iso_in_s, ofs[0]);                 // RL5 RL10
			`IDTP_OFS_TTL_LO,
			`IDTP_OFS_TTL_HI: nxt_rd_data = pick_byte(ttl_in_s, ofs[0]);                 // RL5 RL10
			default:          nxt_rd_data = 8'h00;
		endcase
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_data_ff <= 8'h00;
			rd_oe_ff   <= 1'b0;
		end else begin
			rd_data_ff <= (rd_s && hit) ? nxt_rd_data : 8'h00;
			rd_oe_ff   <= rd_s && hit;                                               // RL1
		end
	end

	// bus driver enable is low while the card drives the data lines
	assign bus_dout      = rd_data_ff;
	assign bus_dout_oe_b = ~rd_oe_ff;

	// ************************************************************
	// interrupt source, edge detect and request pulse
	// ************************************************************
	localparam ST_IDLE  = 2'b01;
	localparam ST_PULSE = 2'b10;

	reg        src_ff;
	reg        src_d_ff;
	reg [`IDTP_PRIME_LEN-1:0] prime_ff;
	reg [1:0]  st_ff;
	reg [1:0]  nxt_st;
	reg [7:0]  cnt_ff;
	reg [7:0]  nxt_cnt;
	reg [2:0]  line_ff;

	reg src_sel;
	always @* begin
		case (srcsel_s)
			`IDTP_SRC_ISO0: src_sel = iso_in_s[0];                                       // RL7
			`IDTP_SRC_ISO1: src_sel = iso_in_s[1];                                       // RL7
			`IDTP_SRC_TTL0: src_sel = ttl_in_s[0];                                       // RL7
			`IDTP_SRC_TTL1: src_sel = ttl_in_s[1];                                       // RL7
			default:        src_sel = 1'b0;
		endcase
	end

	wire line_ok = (line_s >= `IDTP_IRQ_MIN)
	               && (line_s <= `IDTP_IRQ_MAX);                                         // RL9
	wire rise    = src_ff && !src_d_ff;
	wire fall    = !src_ff && src_d_ff;
	// two synchroniser stages and two history bits all hold reset zeros; waiting until
	// every one carries a real pin level stops a false edge when the pin idles high
	wire edge_go = prime_ff[`IDTP_PRIME_LEN-1] && line_ok
	               && ((edge_s == `IDTP_EDGE_RISE) ? rise : fall);                       // RL8 RL11

	// an edge during a pulse is dropped: the host line cannot show two at once
	always @* begin
		nxt_st  = st_ff;
		nxt_cnt = cnt_ff;
		case (st_ff)
			ST_IDLE: begin
				if (edge_go) begin
					nxt_st  = ST_PULSE;                                          // RL11
					nxt_cnt = IRQ_PULSE;
				end
			end
			ST_PULSE: begin
				if (cnt_ff <= 8'h01) begin
					nxt_st  = ST_IDLE;
					nxt_cnt = 8'h00;
				end else begin
					nxt_cnt = cnt_ff - 8'h01;
				end
			end
			default: begin
				nxt_st  = ST_IDLE;
				nxt_cnt = 8'h00;
			end
		endcase
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			src_ff       <= 1'b0;
			src_d_ff     <= 1'b0;
			prime_ff     <= {`IDTP_PRIME_LEN{1'b0}};
			st_ff        <= ST_IDLE;
			cnt_ff       <= 8'h00;
			line_ff      <= `IDTP_IRQ_NONE;
		end else begin
			src_ff       <= src_sel;
			src_d_ff     <= src_ff;
			prime_ff     <= {prime_ff[`IDTP_PRIME_LEN-2:0], 1'b1};
			st_ff        <= nxt_st;
			cnt_ff       <= nxt_cnt;
			if (st_ff == ST_IDLE) begin
				line_ff <= line_s;                                               // RL9
			end
		end
	end

	// one-hot onto lines 2..7; bit 0 is line 2
	genvar gi;
	generate
		for (gi = 0; gi < `IDTP_IRQ_LINES; gi = gi + 1) begin : g_irq
			assign irq_req[gi] = (st_ff == ST_PULSE)
			                     && (line_ff == (`IDTP_IRQ_MIN + gi));               // RL9
		end
	endgenerate

endmodule

// ===== idtp_monitor.sv
`timescale 1ns/10ps
// ****
// port checker
// ****
module idtp_monitor #(
	parameter       CH_W      = 16,
	parameter [7:0] IRQ_PULSE = 8'h04
) (
	input wire            clk,
	input wire            rst_b,
	input wire [9:0]      bus_addr,
	input wire            bus_aen,
	input wire            bus_ior_b,
	input wire            bus_iow_b,
	input wire            bus_dout_oe_b,
	input wire [7:0]      base_select_switch,
	input wire [2:0]      irq_line_jumper,
	input wire            trigger_edge_jumper,
	input wire [1:0]      irq_source_jumper,
	input wire [CH_W-1:0] isolated_input,
	input wire [CH_W-1:0] ttl_input,
	input wire [CH_W-1:0] isolated_output,
	input wire [CH_W-1:0] ttl_output,
	input wire [5:0]      irq_req
);
	// switch on means address bit zero, so the hit compares against the inverse
	// and switch 1 must be off, since the window never drops below hex 200
	wire hit = !bus_aen && !base_select_switch[7] && bus_addr[9:2] == ~base_select_switch;
	wire sel = irq_source_jumper[0];
	wire src = irq_source_jumper[1] ? ttl_input[sel] : isolated_input[sel];
	wire irq = |irq_req;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_pulse; irq [*4] ##1 !irq; endsequence
	property p_oe_rd; $fell(bus_dout_oe_b) |-> $past(hit, 2) && !$past(bus_ior_b, 2); endproperty
	a_oe_rd: assert property (p_oe_rd) else $error("stray drive");
	property p_rd_hit; $fell(bus_ior_b) && hit |-> ##[2:5] !bus_dout_oe_b; endproperty
	a_rd_hit: assert property (p_rd_hit) else $error("hit not driven");
	property p_oe_off; $rose(bus_ior_b) |-> ##[1:6] bus_dout_oe_b; endproperty
	a_oe_off: assert property (p_oe_off) else $error("drive held");
	property p_iso_wr; $changed(isolated_output) |-> $past(hit, 2) && !$past(bus_iow_b, 2); endproperty
	a_iso_wr: assert property (p_iso_wr) else $error("stray iso write");
	property p_ttl_wr; $changed(ttl_output) |-> $past(hit, 2) && !$past(bus_iow_b, 2); endproperty
	a_ttl_wr: assert property (p_ttl_wr) else $error("stray ttl write");
	property p_irq_w; $rose(irq) |-> s_pulse; endproperty
	a_irq_w: assert property (p_irq_w) else $error("pulse width");
	property p_irq_ln; irq |-> irq_req == 6'h01 << (irq_line_jumper - 3'h2); endproperty
	a_irq_ln: assert property (p_irq_ln) else $error("wrong line");
	property p_irq_src; $rose(irq) |-> $past(src, 7) == trigger_edge_jumper
		&& $past(src, 2) != trigger_edge_jumper; endproperty
	a_irq_src: assert property (p_irq_src) else $error("no source edge");
endmodule
bind idtp_dio_port idtp_monitor #(.CH_W(CH_W), .IRQ_PULSE(IRQ_PULSE)) mon (.clk, .rst_b,
	.bus_addr, .bus_aen, .bus_ior_b, .bus_iow_b, .bus_dout_oe_b, .base_select_switch,
	.irq_line_jumper, .trigger_edge_jumper, .irq_source_jumper, .isolated_input, .ttl_input,
	.isolated_output, .ttl_output, .irq_req);

// ===== idtp_host.sv
`timescale 1ns/10ps
// ****
// host bus master model
// ****
module idtp_host (
	input  wire       clk,
	input  wire [7:0] bus_dout,
	input  wire       bus_dout_oe_b,
	output reg  [9:0] bus_addr,
	output reg        bus_aen,
	output reg        bus_ior_b,
	output reg        bus_iow_b,
	output reg  [7:0] bus_din
);
	// idle bus from time zero
	initial begin
		bus_addr = 10'h000;
		bus_aen = 1'b0;
		bus_ior_b = 1'b1;
		bus_iow_b = 1'b1;
		bus_din = 8'h00;
	end
	// one i/o cycle; six clocks cover the strobe sync, read data taken before release
	task io(input [9:0] a, input [7:0] d, input aen, input rd, output [7:0] q, output hit);
		@(posedge clk);
		bus_addr <= a;
		bus_aen <= aen;
		bus_din <= d;
		bus_ior_b <= !rd;
		bus_iow_b <= rd;
		repeat (6) @(posedge clk);
		q = bus_dout;
		hit = !bus_dout_oe_b;
		bus_ior_b <= 1'b1;
		bus_iow_b <= 1'b1;
		bus_din <= ~d;
		repeat (6) @(posedge clk);
	endtask
endmodule

// ===== test_isolated_ttl_dio_port.sv
`timescale 1ns/10ps
module test_isolated_ttl_dio_port;
	reg         clk, rst_b, trigger_edge_jumper, hit;
	reg  [7:0]  base_select_switch, q;
	reg  [2:0]  irq_line_jumper;
	reg  [1:0]  irq_source_jumper;
	reg  [31:0] pins, m;
	wire [9:0]  bus_addr;
	wire [7:0]  bus_din, bus_dout;
	wire        bus_aen, bus_ior_b, bus_iow_b, bus_dout_oe_b;
	wire [15:0] isolated_output, ttl_output;
	wire [5:0]  irq_req;
	integer     errors, check_count, i, s, e, p;
	idtp_dio_port uut (.clk, .rst_b, .bus_addr, .bus_aen, .bus_ior_b, .bus_iow_b, .bus_din,
		.bus_dout, .bus_dout_oe_b, .base_select_switch, .irq_line_jumper,
		.trigger_edge_jumper, .irq_source_jumper, .isolated_input(pins[15:0]),
		.ttl_input(pins[31:16]), .isolated_output, .ttl_output, .irq_req);
	idtp_host host (.clk, .bus_dout, .bus_dout_oe_b, .bus_addr, .bus_aen, .bus_ior_b,
		.bus_iow_b, .bus_din);
	// ****
	// clock and helpers
	// ****
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	task chk(input string n, input [39:0] got, input [39:0] exp);
		check_count = check_count + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("[ERR] %0s expected %h seen %h", n, exp, got);
		end
	endtask
	task report_and_stop;
		if (errors == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// or of irq lines over a fixed window, long enough for sync plus pulse
	task see_irq(input [5:0] exp);
		reg [5:0] got;
		integer k;
		got = 6'h00;
		for (k = 0; k < 12; k = k + 1) begin
			@(posedge clk);
			got = got | irq_req;
		end
		chk("irq_req", got, exp);
	endtask
	// default base: each port offset, write then read back inputs
	task t_ports;
		for (i = 0; i < 4; i = i + 1)
			host.io(10'h300 + i, 8'h5a + 8'h21 * i, 1'b0, 1'b0, q, hit);
		chk("iso_out", isolated_output, 16'h7b5a);
		chk("ttl_out", ttl_output, 16'hbd9c);
		pins <= 32'hc3a5_1e69;
		for (i = 0; i < 4; i = i + 1) begin
			host.io(10'h300 + i, 8'h00, 1'b0, 1'b1, q, hit);
			chk("rd", {hit, q}, 9'h100 | (32'hc3a51e69 >> (8 * i)) & 8'hff);
		end
	endtask
	// lowest, next and hex 3f0 base; neighbours and aen cycles are refused
	task t_decode;
		for (i = 0; i < 3; i = i + 1) begin
			p = (i == 0) ? 10'h200 : (i == 1) ? 10'h204 : 10'h3f0;
			base_select_switch <= ~p[9:2];
			host.io(p + 3, 8'he7 ^ i, 1'b0, 1'b0, q, hit);
			host.io(p + 4, 8'h18, 1'b0, 1'b0, q, hit);
			host.io(p - 1, 8'h42, 1'b0, 1'b0, q, hit);
			host.io(p + 3, 8'h24, 1'b1, 1'b0, q, hit);
			chk("ttl_hi", ttl_output[15:8], 8'he7 ^ i);
			host.io(p + 4, 8'h00, 1'b0, 1'b1, q, hit);
			chk("miss", hit, 1'b0);
			host.io(p, 8'h00, 1'b0, 1'b1, q, hit);
			chk("base_rd", {hit, q}, 9'h169);
		end
	endtask
	// every source, edge and line; other candidate bits and the wrong edge stay quiet
	task t_irq;
		for (p = 0; p < 2; p = p + 1)
			for (s = 0; s < 4; s = s + 1)
				for (e = 0; e < 2; e = e + 1) begin
					i = (s * 2 + e + 2 + p * 2) % 8;
					m = s[1] ? 32'h10000 << s[0] : 32'h1 << s[0];
					irq_source_jumper <= s;
					trigger_edge_jumper <= e;
					irq_line_jumper <= i;
					pins <= e ? 32'hffff_ffff : 32'h0;
					see_irq(6'h00);
					pins <= pins ^ (32'h0003_0003 & ~m);
					see_irq(6'h00);
					pins <= pins ^ m;
					see_irq(i >= 2 ? 6'h01 << (i - 2) : 6'h00);
					pins <= pins ^ m;
					see_irq(6'h00);
				end
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		errors = 0;
		check_count = 0;
		rst_b = 1'b0;
		base_select_switch = 8'h3f;
		irq_line_jumper = 3'h0;
		trigger_edge_jumper = 1'b0;
		irq_source_jumper = 2'h0;
		pins = 32'h0;
		repeat (20) @(posedge clk);
		chk("rst", {bus_dout_oe_b, irq_req, isolated_output, ttl_output}, 39'h40_0000_0000);
		rst_b <= 1'b1;
		t_ports;
		t_decode;
		t_irq;
		report_and_stop;
	end
endmodule
